/* design/nbl_core.sv */
// Nibble core: instruction execution, timer 1 and Avalon-MM register slave
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "nbl_regs.svh"
module nbl_core #(
	parameter int ROM_DEPTH   = `NBL_ROM_DEPTH,
	parameter int STACK_DEPTH = `NBL_STACK_DEPTH
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Avalon-MM slave
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire nbl_pkg::nbl_bus_t avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output nbl_pkg::nbl_bus_t      avs_readdata,
	output logic                   avs_waitrequest
);
	import nbl_pkg::*;

	nbl_state_t busState_reg;
	logic [1:0] cycLeft_reg;
	logic [8:0] instr_reg;
	nbl_nib_t   acc_reg, aux_reg, ptrLow_reg, pcPage_reg;
	nbl_nib_t   accNext, auxNext, ptrLowNext, pcPageNext;
	logic       carry_reg, skip_reg, romTopEn_reg;
	logic       carryNext, skipNext, romTopEnNext;
	logic [1:0] ptrHigh_reg, stackIdx_reg, logicSel_reg;
	logic [1:0] ptrHighNext, stackIdxNext, logicSelNext;
	logic [6:0] pcOffset_reg, pcOffsetNext;
	logic [2:0] tablePage_reg, timer1Ctrl_reg, tablePageNext, timer1CtrlNext;
	logic [7:0] timer1Count_reg, timer1Reload_reg;
	logic [10:0] romAddr_reg, tableAddr, pcInc;
	logic [10:0] returnStack [STACK_DEPTH];
	logic [8:0] rom [ROM_DEPTH];
	logic [8:0] romWord;
	logic [4:0] sum;
	nbl_op_t    curOp;
	logic       execLast, doExec, issueInstr, regWrite, pushEn, timer1Write;
	nbl_bus_t   coreWord, readMux, coreMerged, pcMerged, addrMerged, dataMerged;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	nbl_mem_if memBus ();
	nbl_ram u_ram (
		.clk  (clk),
		.port (memBus)
	);
	assign memBus.addr = {ptrHigh_reg, ptrLow_reg};

	function automatic nbl_op_t decodeOp(input logic [8:0] w);
		nbl_op_t op;
		op = OP_NONE;
		if (w == `NBL_OPC_ADD_CARRY) op = OP_ADD_CARRY;
		if (w == `NBL_OPC_ROTATE) op = OP_ROTATE;
		if (w == `NBL_OPC_CMP_MEM) op = OP_CMP_MEM;
		if (w == `NBL_OPC_RETURN) op = OP_RETURN;
		if (w == `NBL_OPC_RET_SKIP) op = OP_RET_SKIP;
		if (w == `NBL_OPC_TMR_READ) op = OP_TMR_READ;
		if (w == `NBL_OPC_TMR_WRITE) op = OP_TMR_WRITE;
		if (w == `NBL_OPC_TMR_CTRL) op = OP_TMR_CTRL;
		if (w == `NBL_OPC_LSEL) op = OP_LSEL;
		if (w == `NBL_OPC_LOGIC) op = OP_LOGIC;
		if (w == `NBL_OPC_TOPEN) op = OP_TOPEN;
		if (w == `NBL_OPC_TPAGE) op = OP_TPAGE;
		if ((w & `NBL_MASK_NIB) == `NBL_OPC_TABLE) op = OP_TABLE;
		if ((w & `NBL_MASK_NIB) == `NBL_OPC_CMP_IMM) op = OP_CMP_IMM;
		if ((w & `NBL_MASK_J) == `NBL_OPC_RAM_LOAD) op = OP_RAM_LOAD;
		if ((w & `NBL_MASK_J) == `NBL_OPC_XCHG) op = OP_XCHG;
		if ((w & `NBL_MASK_J) == `NBL_OPC_XCHG_DEC) op = OP_XCHG_DEC;
		if ((w & `NBL_MASK_J) == `NBL_OPC_XCHG_INC) op = OP_XCHG_INC;
		if ((w & `NBL_MASK_ADDR) == `NBL_OPC_CALL) op = OP_CALL;
		if ((w & `NBL_MASK_ADDR) == `NBL_OPC_BRANCH) op = OP_BRANCH;
		return op;
	endfunction : decodeOp

	function automatic logic [1:0] cycleCount(input nbl_op_t op, input logic skipping);
		logic [1:0] n;
		n = `NBL_CYC_ONE;
		if (op == OP_TABLE) n = `NBL_CYC_TABLE;
		if (op == OP_RETURN || op == OP_RET_SKIP) n = `NBL_CYC_RETURN;
		if (skipping) n = `NBL_CYC_ONE;
		return n;
	endfunction : cycleCount

	function automatic nbl_bus_t beMerge(input nbl_bus_t old, input nbl_bus_t upd, input logic [3:0] be);
		nbl_bus_t r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = upd[i*8 +: 8];
		end
		return r;
	endfunction : beMerge

	assign curOp      = decodeOp(instr_reg);
	assign execLast   = busState_reg == ST_EXEC && cycLeft_reg == 2'h0;
	assign doExec     = execLast && !skip_reg;
	assign issueInstr = busState_reg == ST_IDLE && avs_write && avs_address == `NBL_OFS_INSTR && avs_byteenable[0];
	assign regWrite   = busState_reg == ST_DONE && avs_write && avs_address != `NBL_OFS_INSTR;
	assign sum        = {1'b0, acc_reg} + {1'b0, memBus.rdata} + {4'h0, carry_reg};
	assign tableAddr  = {instr_reg[3:0], tablePage_reg, acc_reg};
	assign romWord    = rom[tableAddr];
	assign pcInc      = {pcPage_reg, pcOffset_reg} + 11'h001;
	assign coreMerged = beMerge(coreWord, avs_writedata, avs_byteenable);
	assign pcMerged   = beMerge({21'h0, pcPage_reg, pcOffset_reg}, avs_writedata, avs_byteenable);
	assign addrMerged = beMerge({21'h0, romAddr_reg}, avs_writedata, avs_byteenable);
	assign dataMerged = beMerge(readMux, avs_writedata, avs_byteenable);
	assign avs_waitrequest = busState_reg != ST_DONE;

	always_comb begin
		coreWord = '0;
		coreWord[`NBL_CORE_ACC]   = acc_reg;
		coreWord[`NBL_CORE_AUX]   = aux_reg;
		coreWord[`NBL_CORE_PLOW]  = ptrLow_reg;
		coreWord[`NBL_CORE_PHIGH] = ptrHigh_reg;
		coreWord[`NBL_CORE_CARRY] = carry_reg;
		coreWord[`NBL_CORE_TPAGE] = tablePage_reg;
		coreWord[`NBL_CORE_SKIP]  = skip_reg;
		coreWord[`NBL_CORE_SIDX]  = stackIdx_reg;
	end

	always_comb begin
		readMux = '0;
		unique case (avs_address)
			`NBL_OFS_INSTR:   readMux[`NBL_WORD_FIELD] = instr_reg;
			`NBL_OFS_CORE:    readMux = coreWord;
			`NBL_OFS_PC:      readMux[`NBL_PC_FIELD] = {pcPage_reg, pcOffset_reg};
			`NBL_OFS_TIMER: begin
				readMux[`NBL_TMR_COUNT]  = timer1Count_reg;
				readMux[`NBL_TMR_RELOAD] = timer1Reload_reg;
				readMux[`NBL_TMR_CTRL]   = timer1Ctrl_reg;
				readMux[`NBL_TMR_LSEL]   = logicSel_reg;
				readMux[`NBL_TMR_TOPEN]  = romTopEn_reg;
			end
			`NBL_OFS_ROMADDR: readMux[`NBL_PC_FIELD] = romAddr_reg;
			`NBL_OFS_ROMDATA: readMux[`NBL_WORD_FIELD] = rom[romAddr_reg];
			default:          readMux = '0;
		endcase
	end

	// Everything but the counter and skip flag keeps its value unless the instruction names it
	always_comb begin
		accNext        = acc_reg;
		auxNext        = aux_reg;
		carryNext      = carry_reg;
		ptrLowNext     = ptrLow_reg;
		ptrHighNext    = ptrHigh_reg;
		pcPageNext     = pcPage_reg;
		pcOffsetNext   = pcOffset_reg;
		stackIdxNext   = stackIdx_reg;
		skipNext       = skip_reg;
		logicSelNext   = logicSel_reg;
		romTopEnNext   = romTopEn_reg;
		tablePageNext  = tablePage_reg;
		timer1CtrlNext = timer1Ctrl_reg;
		memBus.we      = 1'b0;
		memBus.wdata   = acc_reg;
		pushEn         = 1'b0;
		timer1Write    = 1'b0;
		if (execLast) begin
			{pcPageNext, pcOffsetNext} = pcInc;
			skipNext = 1'b0;
		end
		if (doExec) begin
			unique case (curOp)
				OP_NONE: begin
				end
				OP_RAM_LOAD: begin
					accNext = memBus.rdata;
					ptrHighNext = ptrHigh_reg ^ instr_reg[1:0];
				end
				OP_XCHG, OP_XCHG_DEC, OP_XCHG_INC: begin
					accNext = memBus.rdata;
					memBus.we = 1'b1;
					ptrHighNext = ptrHigh_reg ^ instr_reg[1:0];
					if (curOp == OP_XCHG_DEC) ptrLowNext = ptrLow_reg - 4'h1;
					if (curOp == OP_XCHG_INC) ptrLowNext = ptrLow_reg + 4'h1;
				end
				OP_ADD_CARRY: {carryNext, accNext} = sum;
				OP_ROTATE: begin
					accNext = {carry_reg, acc_reg[3:1]};
					carryNext = acc_reg[0];
				end
				OP_CMP_IMM: skipNext = acc_reg == instr_reg[3:0];
				OP_CMP_MEM: skipNext = acc_reg == memBus.rdata;
				OP_TABLE: begin
					// Push then pop: index ends unchanged, entry above it is overwritten
					pushEn = 1'b1;
					auxNext = romWord[7:4];
					accNext = romWord[3:0];
					if (romTopEn_reg) carryNext = romWord[8];
				end
				OP_CALL: begin
					pushEn = 1'b1;
					stackIdxNext = stackIdx_reg + 2'h1;
					pcPageNext = `NBL_CALL_PAGE;
					pcOffsetNext = instr_reg[6:0];
				end
				OP_BRANCH: pcOffsetNext = instr_reg[6:0];
				OP_RETURN, OP_RET_SKIP: begin
					{pcPageNext, pcOffsetNext} = returnStack[stackIdx_reg];
					stackIdxNext = stackIdx_reg - 2'h1;
					skipNext = curOp == OP_RET_SKIP;
				end
				OP_TMR_READ: {auxNext, accNext} = timer1Count_reg;
				OP_TMR_WRITE: timer1Write = 1'b1;
				OP_TMR_CTRL: timer1CtrlNext = acc_reg[2:0];
				OP_LSEL: logicSelNext = acc_reg[1:0];
				OP_LOGIC: begin
					// Unused select code leaves the accumulator as it is
					if (logicSel_reg == `NBL_LSEL_XOR) accNext = acc_reg ^ memBus.rdata;
					if (logicSel_reg == `NBL_LSEL_OR) accNext = acc_reg | memBus.rdata;
					if (logicSel_reg == `NBL_LSEL_AND) accNext = acc_reg & memBus.rdata;
				end
				OP_TOPEN: romTopEnNext = 1'b1;
				OP_TPAGE: tablePageNext = acc_reg[2:0];
			endcase
		end
		if (regWrite && avs_address == `NBL_OFS_CORE) begin
			accNext       = coreMerged[`NBL_CORE_ACC];
			auxNext       = coreMerged[`NBL_CORE_AUX];
			ptrLowNext    = coreMerged[`NBL_CORE_PLOW];
			ptrHighNext   = coreMerged[`NBL_CORE_PHIGH];
			carryNext     = coreMerged[`NBL_CORE_CARRY];
			tablePageNext = coreMerged[`NBL_CORE_TPAGE];
		end
		if (regWrite && avs_address == `NBL_OFS_PC) begin
			{pcPageNext, pcOffsetNext} = pcMerged[`NBL_PC_FIELD];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_reg        <= 4'h0;
			aux_reg        <= 4'h0;
			carry_reg      <= 1'b0;
			ptrLow_reg     <= 4'h0;
			ptrHigh_reg    <= 2'h0;
			pcPage_reg     <= 4'h0;
			pcOffset_reg   <= 7'h00;
			stackIdx_reg   <= `NBL_RST_SIDX;
			skip_reg       <= 1'b0;
			logicSel_reg   <= 2'h0;
			romTopEn_reg   <= 1'b0;
			tablePage_reg  <= 3'h0;
			timer1Ctrl_reg <= 3'h0;
		end else begin
			acc_reg        <= accNext;
			aux_reg        <= auxNext;
			carry_reg      <= carryNext;
			ptrLow_reg     <= ptrLowNext;
			ptrHigh_reg    <= ptrHighNext;
			pcPage_reg     <= pcPageNext;
			pcOffset_reg   <= pcOffsetNext;
			stackIdx_reg   <= stackIdxNext;
			skip_reg       <= skipNext;
			logicSel_reg   <= logicSelNext;
			romTopEn_reg   <= romTopEnNext;
			tablePage_reg  <= tablePageNext;
			timer1Ctrl_reg <= timer1CtrlNext;
		end
	end

	always_ff @(posedge clk) begin
		if (pushEn) begin
			returnStack[stackIdx_reg + 2'h1] <= pcInc;
		end
		if (regWrite && avs_address == `NBL_OFS_ROMDATA) begin
			rom[romAddr_reg] <= dataMerged[`NBL_WORD_FIELD];
		end
	end

	// Auto-increment lets software stream a program image through one register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			romAddr_reg <= 11'h000;
		end else if (regWrite && avs_address == `NBL_OFS_ROMADDR) begin
			romAddr_reg <= addrMerged[`NBL_PC_FIELD];
		end else if (regWrite && avs_address == `NBL_OFS_ROMDATA) begin
			romAddr_reg <= romAddr_reg + 11'h001;
		end
	end

	// Reload write while running can race an underflow; counter keeps ticking
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timer1Count_reg  <= 8'h00;
			timer1Reload_reg <= 8'h00;
		end else begin
			if (timer1Write) begin
				timer1Reload_reg <= {aux_reg, acc_reg};
			end
			if (timer1Write && !timer1Ctrl_reg[`NBL_TMR_RUN]) begin
				timer1Count_reg <= {aux_reg, acc_reg};
			end else if (timer1Ctrl_reg[`NBL_TMR_RUN]) begin
				timer1Count_reg <= (timer1Count_reg == 8'h00) ? timer1Reload_reg : timer1Count_reg - 8'h01;
			end
		end
	end

	// Instruction writes hold waitrequest for the whole execution
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busState_reg <= ST_IDLE;
			cycLeft_reg  <= 2'h0;
			instr_reg    <= 9'h000;
			avs_readdata <= 32'h0000_0000;
		end else begin
			unique case (busState_reg)
				ST_IDLE: begin
					if (issueInstr) begin
						instr_reg    <= avs_writedata[`NBL_WORD_FIELD];
						cycLeft_reg  <= cycleCount(decodeOp(avs_writedata[`NBL_WORD_FIELD]), skip_reg) - 2'h1;
						busState_reg <= ST_EXEC;
					end else if (avs_read || avs_write) begin
						avs_readdata <= readMux;
						busState_reg <= ST_DONE;
					end
				end
				ST_EXEC: begin
					if (cycLeft_reg == 2'h0) begin
						busState_reg <= ST_DONE;
					end else begin
						cycLeft_reg <= cycLeft_reg - 2'h1;
					end
				end
				ST_DONE: busState_reg <= ST_IDLE;
			endcase
		end
	end

	property p_skip_suppress;
		execLast && skip_reg |=> acc_reg == $past(acc_reg) && carry_reg == $past(carry_reg) && !skip_reg;
	endproperty
	a_skip_suppress: assert property (p_skip_suppress) else $error("skipped instruction took effect");
	property p_skip_short;
		issueInstr && skip_reg && decodeOp(avs_writedata[8:0]) == OP_TABLE |=> execLast ##1 busState_reg == ST_DONE;
	endproperty
	a_skip_short: assert property (p_skip_short) else $error("skipped lookup not one cycle");
	property p_table_cycles;
		issueInstr && !skip_reg && decodeOp(avs_writedata[8:0]) == OP_TABLE |=> !execLast [*2] ##1 execLast;
	endproperty
	a_table_cycles: assert property (p_table_cycles) else $error("lookup cycle count wrong");
	property p_branch;
		doExec && curOp == OP_BRANCH |=> pcOffset_reg == instr_reg[6:0] && pcPage_reg == $past(pcPage_reg);
	endproperty
	a_branch: assert property (p_branch) else $error("branch fields wrong");
	property p_call;
		doExec && curOp == OP_CALL |=> stackIdx_reg == $past(stackIdx_reg) + 2'h1
			&& pcPage_reg == `NBL_CALL_PAGE && returnStack[stackIdx_reg] == $past(pcInc);
	endproperty
	a_call: assert property (p_call) else $error("call push wrong");
	property p_table;
		doExec && curOp == OP_TABLE && romTopEn_reg |=> carry_reg == $past(romWord[8])
			&& {aux_reg, acc_reg} == $past(romWord[7:0]) && stackIdx_reg == $past(stackIdx_reg);
	endproperty
	a_table: assert property (p_table) else $error("table lookup result wrong");
	property p_xchg_inc;
		doExec && curOp == OP_XCHG_INC |=> ptrLow_reg == $past(ptrLow_reg) + 4'h1
			&& ptrHigh_reg == ($past(ptrHigh_reg) ^ instr_reg[1:0]);
	endproperty
	a_xchg_inc: assert property (p_xchg_inc) else $error("pointer update wrong");
	property p_add_carry;
		doExec && curOp == OP_ADD_CARRY |=> {carry_reg, acc_reg}
			== 5'($past(acc_reg)) + 5'($past(memBus.rdata)) + 5'($past(carry_reg));
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");
	property p_rotate;
		doExec && curOp == OP_ROTATE |=> carry_reg == $past(acc_reg[0]) && acc_reg[3] == $past(carry_reg);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate wrong");
	property p_cmp_imm;
		doExec && curOp == OP_CMP_IMM |=> skip_reg == ($past(acc_reg) == instr_reg[3:0]);
	endproperty
	a_cmp_imm: assert property (p_cmp_imm) else $error("compare skip wrong");
	property p_tmr_write;
		doExec && curOp == OP_TMR_WRITE |=> timer1Reload_reg == {$past(aux_reg), $past(acc_reg)}
			&& ($past(timer1Ctrl_reg[0]) || timer1Count_reg == timer1Reload_reg);
	endproperty
	a_tmr_write: assert property (p_tmr_write) else $error("timer write wrong");
	property p_logic_and;
		doExec && curOp == OP_LOGIC && logicSel_reg == `NBL_LSEL_AND |=> acc_reg == ($past(acc_reg) & $past(memBus.rdata));
	endproperty
	a_logic_and: assert property (p_logic_and) else $error("logic AND wrong");
	c_table: cover property (doExec && curOp == OP_TABLE);
	c_ret_skip: cover property (doExec && curOp == OP_RET_SKIP ##[1:20] execLast && skip_reg);
	c_tmr_run: cover property (doExec && curOp == OP_TMR_WRITE && timer1Ctrl_reg[`NBL_TMR_RUN]);
endmodule : nbl_core

/* design/nbl_regs.svh */
// Register offsets, field positions, instruction codes and counts for the nibble core
// Overview of operation
// - A met skip condition suppresses the next instruction's effect; that instruction then takes one cycle.
// - A skipped table lookup call, return or return-and-skip takes exactly one cycle.
// - The 11-bit program counter is a 4-bit page field and a 7-bit offset field loaded separately.
// - Four 11-bit return stack entries under a 2-bit index; calls bump and store, returns reload and drop.
// - RAM is addressed by the 2-bit pointer-high joined to the 4-bit pointer-low.
// - Table lookup pushes the counter, takes page p and builds the offset from table page and accumulator.
// - Table lookup puts ROM bits 7..4 in aux, 3..0 in acc, bit 8 in carry when enabled, then pops.
// - RAM load and exchanges move or swap acc with memory and XOR pointer-high with j; the dec/inc exchanges step pointer-low.
// - Add-with-carry sums acc, memory and carry into acc with the carry-out in the carry flag.
// - Rotate shifts acc right through carry: old carry to bit 3, old bit 0 to carry.
// - Compare with immediate or memory skips the next instruction on equality.
// - Timer read puts count bits 7..4 in aux and 3..0 in acc.
// - Timer write loads reload from aux and acc, and the counter too only while stopped.
// - Timer control is 3 bits loaded from acc bits 2..0.
// - A 2-bit logic select picks XOR, OR or AND for the logic instruction.
`ifndef NBL_REGS_SVH
`define NBL_REGS_SVH
`define NBL_OFS_INSTR    5'h00
`define NBL_OFS_CORE     5'h04
`define NBL_OFS_PC       5'h08
`define NBL_OFS_TIMER    5'h0c
`define NBL_OFS_ROMADDR  5'h10
`define NBL_OFS_ROMDATA  5'h14
`define NBL_CORE_ACC     3:0
`define NBL_CORE_AUX     7:4
`define NBL_CORE_PLOW    11:8
`define NBL_CORE_PHIGH   13:12
`define NBL_CORE_CARRY   16
`define NBL_CORE_TPAGE   22:20
`define NBL_CORE_SKIP    24
`define NBL_CORE_SIDX    29:28
`define NBL_PC_FIELD     10:0
`define NBL_TMR_COUNT    7:0
`define NBL_TMR_RELOAD   15:8
`define NBL_TMR_CTRL     18:16
`define NBL_TMR_LSEL     21:20
`define NBL_TMR_TOPEN    24
`define NBL_TMR_RUN      0
`define NBL_WORD_FIELD   8:0
`define NBL_OPC_ADD_CARRY 9'h00b
`define NBL_OPC_ROTATE    9'h01d
`define NBL_OPC_CMP_MEM   9'h026
`define NBL_OPC_RETURN    9'h044
`define NBL_OPC_RET_SKIP  9'h045
`define NBL_OPC_TMR_READ  9'h070
`define NBL_OPC_TMR_WRITE 9'h071
`define NBL_OPC_TMR_CTRL  9'h072
`define NBL_OPC_LSEL      9'h073
`define NBL_OPC_LOGIC     9'h074
`define NBL_OPC_TOPEN     9'h075
`define NBL_OPC_TPAGE     9'h076
`define NBL_OPC_TABLE     9'h080
`define NBL_OPC_CMP_IMM   9'h0b0
`define NBL_OPC_RAM_LOAD  9'h0c0
`define NBL_OPC_XCHG      9'h0c4
`define NBL_OPC_XCHG_DEC  9'h0c8
`define NBL_OPC_XCHG_INC  9'h0cc
`define NBL_OPC_CALL      9'h100
`define NBL_OPC_BRANCH    9'h180
`define NBL_MASK_NIB      9'h1f0
`define NBL_MASK_J        9'h1fc
`define NBL_MASK_ADDR     9'h180
`define NBL_CALL_PAGE     4'h2
`define NBL_RST_SIDX      2'h3
`define NBL_CYC_ONE       2'h1
`define NBL_CYC_RETURN    2'h2
`define NBL_CYC_TABLE     2'h3
`define NBL_LSEL_XOR      2'h0
`define NBL_LSEL_OR       2'h1
`define NBL_LSEL_AND      2'h2
`define NBL_ROM_DEPTH     2048
`define NBL_RAM_DEPTH     64
`define NBL_STACK_DEPTH   4
`endif

/* design/nbl_pkg.sv */
// Types shared by the nibble core modules
package nbl_pkg;
	typedef logic [31:0] nbl_bus_t;
	typedef logic [3:0]  nbl_nib_t;
	typedef enum logic [4:0] {
		OP_NONE, OP_RAM_LOAD, OP_XCHG, OP_XCHG_DEC, OP_XCHG_INC, OP_ADD_CARRY, OP_ROTATE,
		OP_CMP_IMM, OP_CMP_MEM, OP_TABLE, OP_CALL, OP_BRANCH, OP_RETURN, OP_RET_SKIP,
		OP_TMR_READ, OP_TMR_WRITE, OP_TMR_CTRL, OP_LSEL, OP_LOGIC, OP_TOPEN, OP_TPAGE
	} nbl_op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_DONE = 3'h4
	} nbl_state_t;
endpackage : nbl_pkg

/* design/nbl_mem_if.sv */
// Data memory port between the core and the nibble RAM
`timescale 1ns/10ps
interface nbl_mem_if;
	logic [5:0] addr;
	logic [3:0] wdata;
	logic       we;
	logic [3:0] rdata;
	modport core (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface : nbl_mem_if

/* design/nbl_ram.sv */
// Nibble-wide data RAM with asynchronous read
`timescale 1ns/10ps
`include "nbl_regs.svh"
module nbl_ram #(
	parameter int DEPTH = `NBL_RAM_DEPTH
) (
	// Clock
	input wire logic clk,
	// Core port
	nbl_mem_if.mem   port
);
	import nbl_pkg::*;
	// No reset: contents are undefined until written, as on the real part
	nbl_nib_t cells [DEPTH];
	assign port.rdata = cells[port.addr];
	always_ff @(posedge clk) begin
		if (port.we) begin
			cells[port.addr] <= port.wdata;
		end
	end
endmodule : nbl_ram

/* test/nbl_core_tb.sv */
// Self-checking bench for the nibble core, driven over its register bus
`timescale 1ns/10ps
`include "nbl_regs.svh"
module testbench;
	import nbl_pkg::*;
	localparam logic [4:0] CORE = `NBL_OFS_CORE;
	localparam logic [4:0] PC   = `NBL_OFS_PC;
	localparam logic [4:0] TMR  = `NBL_OFS_TIMER;
	// XOR, OR, AND of c with 7, low nibble first
	localparam logic [11:0] LOGIC_EXP = 12'h4fb;
	logic       clk;
	logic       rstn;
	logic [4:0] addr;
	logic       rdEn;
	logic       wrEn;
	nbl_bus_t   wdata;
	nbl_bus_t   rdata;
	logic       waitReq;
	nbl_bus_t   q;
	int         n;
	int         errors;
	int         cmp_count;

	nbl_core uut (.clk(clk), .rstn(rstn), .avs_address(addr), .avs_read(rdEn), .avs_write(wrEn),
		.avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitReq));

	always #20 clk = ~clk;

	task end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	task chk(input nbl_bus_t got, input nbl_bus_t exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chkn(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			errors++;
			$display("Error at %0t: cycles %h expected %h", $time, got, exp);
		end
	endtask : chkn

	// Holds the request until waitrequest is sampled low; n counts edges
	task bus(input logic w, input logic [4:0] a, input nbl_bus_t d);
		@(posedge clk);
		rdEn  <= !w;
		wrEn  <= w;
		addr  <= a;
		wdata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitReq !== 1'b0 && n < 20);
		q = rdata;
		rdEn <= 1'b0;
		wrEn <= 1'b0;
		if (n >= 20) begin
			errors++;
			end_sim();
		end
	endtask : bus

	task wr(input logic [4:0] a, input nbl_bus_t d);
		bus(1'b1, a, d);
	endtask : wr

	task rd(input logic [4:0] a, input nbl_bus_t e, input nbl_bus_t m = 32'hffff_ffff);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rd

	// Edges counted include the taking edge and the answer edge
	task ex(input logic [8:0] op, input int c);
		bus(1'b1, `NBL_OFS_INSTR, {23'h0, op});
		chkn(n, c + 2);
	endtask : ex

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		addr = 5'h00;
		rdEn = 1'b0;
		wrEn = 1'b0;
		wdata = 32'h0;
		errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(CORE, 32'h3000_0000);
		rd(PC, 32'h0);
		rd(TMR, 32'h0);
		wr(5'h18, 32'hffff_ffff);
		rd(5'h18, 32'h0);
		$display("Test reset done");
		// RAM content is unknown until the first exchange writes it
		wr(CORE, 32'h0000_1205);
		ex(`NBL_OPC_XCHG, 1);
		wr(CORE, 32'h0000_120a);
		ex(`NBL_OPC_XCHG_INC | 9'h003, 1);
		rd(CORE, 32'h3000_2305);
		wr(CORE, 32'h0000_1200);
		ex(`NBL_OPC_RAM_LOAD | 9'h001, 1);
		rd(CORE, 32'h3000_020a);
		wr(CORE, 32'h0001_1207);
		ex(`NBL_OPC_XCHG_DEC | 9'h002, 1);
		rd(CORE, 32'h3001_310a);
		$display("Test ram done");
		wr(CORE, 32'h0001_120c);
		ex(`NBL_OPC_ADD_CARRY, 1);
		rd(CORE, 32'h3001_1204);
		ex(`NBL_OPC_ROTATE, 1);
		rd(CORE, 32'h3000_120a);
		ex(`NBL_OPC_CMP_MEM, 1);
		rd(CORE, 32'h3000_120a);
		wr(PC, 32'h5);
		ex(`NBL_OPC_CMP_IMM | 9'h00a, 1);
		rd(CORE, 32'h3100_120a);
		ex(`NBL_OPC_ROTATE, 1);
		rd(CORE, 32'h3000_120a);
		rd(PC, 32'h7);
		wr(CORE, 32'h0000_1207);
		ex(`NBL_OPC_CMP_MEM, 1);
		ex(`NBL_OPC_ADD_CARRY, 1);
		rd(CORE, 32'h3000_1207);
		$display("Test arith done");
		wr(PC, 32'h10);
		ex(`NBL_OPC_CALL | 9'h025, 1);
		rd(PC, 32'h125);
		rd(CORE, 32'h0, 32'h3000_0000);
		ex(`NBL_OPC_BRANCH | 9'h011, 1);
		rd(PC, 32'h111);
		ex(`NBL_OPC_RETURN, 2);
		rd(PC, 32'h11);
		rd(CORE, 32'h3000_0000, 32'h3000_0000);
		ex(`NBL_OPC_CALL | 9'h025, 1);
		ex(`NBL_OPC_RET_SKIP, 2);
		rd(CORE, 32'h3100_0000, 32'h3100_0000);
		ex(`NBL_OPC_RETURN, 1);
		rd(PC, 32'h13);
		rd(CORE, 32'h3000_0000, 32'h3100_0000);
		$display("Test stack done");
		wr(`NBL_OFS_ROMADDR, 32'h1d6);
		wr(`NBL_OFS_ROMDATA, 32'h1a5);
		wr(CORE, 32'h0050_0006);
		wr(PC, 32'h10);
		ex(`NBL_OPC_TABLE | 9'h003, 3);
		rd(CORE, 32'h3050_00a5);
		rd(PC, 32'h11);
		ex(`NBL_OPC_TOPEN, 1);
		wr(CORE, 32'h0050_0006);
		ex(`NBL_OPC_TABLE | 9'h003, 3);
		rd(CORE, 32'h3051_00a5);
		ex(`NBL_OPC_CMP_IMM | 9'h005, 1);
		ex(`NBL_OPC_TABLE | 9'h003, 1);
		rd(CORE, 32'h3051_00a5);
		wr(CORE, 32'h5);
		ex(`NBL_OPC_TPAGE, 1);
		rd(CORE, 32'h3050_0005);
		$display("Test table done");
		wr(CORE, 32'h2);
		ex(`NBL_OPC_TMR_CTRL, 1);
		wr(CORE, 32'h3c);
		ex(`NBL_OPC_TMR_WRITE, 1);
		rd(TMR, 32'h0102_3c3c);
		wr(CORE, 32'h0);
		ex(`NBL_OPC_TMR_READ, 1);
		rd(CORE, 32'h3000_003c);
		// Count moves while running, so only reload and control are checked
		wr(CORE, 32'hf);
		ex(`NBL_OPC_TMR_CTRL, 1);
		rd(TMR, 32'h0007_3c00, 32'h0007_ff00);
		wr(CORE, 32'h55);
		ex(`NBL_OPC_TMR_WRITE, 1);
		rd(TMR, 32'h0007_5500, 32'h0007_ff00);
		$display("Test timer done");
		// RAM at pointer 12 still holds 7 from the last exchange
		for (int i = 0; i < 3; i++) begin
			wr(CORE, 32'h0000_1200 | 32'(i));
			ex(`NBL_OPC_LSEL, 1);
			rd(TMR, 32'(i) << 20, 32'h0030_0000);
			wr(CORE, 32'h0000_120c);
			ex(`NBL_OPC_LOGIC, 1);
			rd(CORE, 32'h3000_1200 | {28'h0, LOGIC_EXP[i*4 +: 4]});
		end
		$display("Test logic done");
		end_sim();
	end
endmodule : testbench
